// file: dv/sgc_global_ctrl_monitor.sv
`include "sgc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sgc_global_ctrl_monitor #(
	parameter int ADDR_W = 8
) (
	// Clock, reset, APB
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic              pready,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	// Packet strobes
	input wire logic              rxFrameValid,
	input wire logic [10:0]       rxFrameLen,
	input wire logic              rxFrameTagged,
	input wire logic              frameCheckValid,
	input wire logic              frameDrop,
	input wire logic              rxIgmpValid,
	input wire logic              igmpToHost,
	input wire logic              sniffValid,
	input wire logic              sniffSrcMatch,
	input wire logic              sniffDstMatch,
	input wire logic              sniffMirror,
	input wire logic [3:0]        queueNotEmpty,
	input wire logic              txPick,
	input wire logic              grantValid,
	input wire logic [1:0]        grantQueue,
	input wire logic              vidValid,
	input wire logic [11:0]       vidIn,
	input wire logic              vidOutValid,
	input wire logic [11:0]       vidOut,
	// Levels
	input wire logic              schedWfq,
	input wire logic              vlanEnable,
	input wire logic              hostHalfDuplex,
	input wire logic              hostFlowCtrl,
	input wire logic              tenMegabitSelect
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic wrEn;
	assign wrEn = psel && penable && pwrite && pready;

	a_frame_keep: assert property (
		rxFrameValid && rxFrameLen <= (rxFrameTagged ? `SGC_LEN_TAGGED : `SGC_LEN_UNTAGGED)
		|=> frameCheckValid && !frameDrop) else $error("legal frame dropped");
	a_frame_huge: assert property (
		rxFrameValid && rxFrameLen > `SGC_LEN_HUGE |=> frameDrop) else $error("oversize kept");
	a_igmp_cause: assert property (
		igmpToHost |-> $past(rxIgmpValid)) else $error("igmp forward without packet");
	a_sniff_both: assert property (
		sniffValid && sniffSrcMatch && sniffDstMatch |=> sniffMirror) else $error("no mirror");
	a_sniff_none: assert property (
		sniffValid && !sniffSrcMatch && !sniffDstMatch |=> !sniffMirror) else $error("mirror");
	a_grant_busy: assert property (
		grantValid |-> $past(txPick) && (($past(queueNotEmpty) >> grantQueue) & 4'h1) == 4'h1)
		else $error("grant to empty queue");
	a_pick_idle: assert property (
		txPick && queueNotEmpty == 4'h0 |=> !grantValid) else $error("grant with no queue");
	a_vid_keep: assert property (
		vidValid && vidIn != 12'h000 |=> vidOutValid && vidOut == $past(vidIn))
		else $error("valid vid altered");
	a_host_levels: assert property (
		wrEn && paddr == 8'h18 |-> ##2 {hostHalfDuplex, hostFlowCtrl, tenMegabitSelect}
		== $past(pwdata[6:4], 2)) else $error("host levels wrong");
	a_vlan_levels: assert property (
		wrEn && paddr == 8'h14 |-> ##2 {vlanEnable, schedWfq}
		== {$past(pwdata[7], 2), $past(pwdata[3], 2)}) else $error("vlan levels wrong");

	c_drop: cover property (rxFrameValid ##1 frameDrop);
	c_wfq: cover property (schedWfq && grantValid);
	c_mirror: cover property (sniffMirror && igmpToHost);
endmodule : sgc_global_ctrl_monitor

bind sgc_global_ctrl sgc_global_ctrl_monitor #(.ADDR_W(ADDR_W)) u_sgc_global_ctrl_monitor (
	.clk, .rst_b, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .rxFrameValid,
	.rxFrameLen, .rxFrameTagged, .frameCheckValid, .frameDrop, .rxIgmpValid, .igmpToHost,
	.sniffValid, .sniffSrcMatch, .sniffDstMatch, .sniffMirror, .queueNotEmpty, .txPick,
	.grantValid, .grantQueue, .vidValid, .vidIn, .vidOutValid, .vidOut, .schedWfq,
	.vlanEnable, .hostHalfDuplex, .hostFlowCtrl, .tenMegabitSelect
);

`default_nettype wire

// file: dv/sgc_global_ctrl_tb.sv
`include "sgc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sgc_global_ctrl_tb;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, erv;
	logic        rxFrameValid, rxFrameTagged, frameCheckValid, frameDrop, rxIgmpValid;
	logic        igmpToHost, sniffValid, sniffSrcMatch, sniffDstMatch, sniffMirror;
	logic        txPick, portStrictPrio, grantValid, schedWfq, vidValid, vidOutValid;
	logic        vlanEnable, hostHalfDuplex, hostFlowCtrl, tenMegabitSelect;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [10:0] rxFrameLen, lim;
	logic [3:0]  queueNotEmpty;
	logic [1:0]  grantQueue;
	logic [11:0] vidIn, portVid, vidOut;
	logic [10:0] lens [8] = '{11'h5EE, 11'h5EF, 11'h5F2, 11'h5F3, 11'h600, 11'h601,
		11'h77C, 11'h77D};
	int          n_fail, compares, cyc;

	sgc_global_ctrl u_sgc_global_ctrl (
		.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rxFrameValid, .rxFrameLen, .rxFrameTagged, .frameCheckValid, .frameDrop,
		.rxIgmpValid, .igmpToHost, .sniffValid, .sniffSrcMatch, .sniffDstMatch,
		.sniffMirror, .queueNotEmpty, .txPick, .portStrictPrio, .grantValid, .grantQueue,
		.schedWfq, .vidValid, .vidIn, .portVid, .vidOutValid, .vidOut, .vlanEnable,
		.hostHalfDuplex, .hostFlowCtrl, .tenMegabitSelect
	);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic close_out;
		$display("Checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Ends on the sampling edge; next call waits an edge before setup
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) begin
			@(posedge clk);
		end
		rdv = prdata;
		erv = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
		apb(1'h0, a, 32'h0);
		chk("prdata", rdv, exp);
		chk("pslverr", erv, err);
	endtask : rd

	task automatic frm(input logic [10:0] len, input logic tg, input logic exp);
		@(posedge clk);
		{rxFrameValid, rxFrameLen, rxFrameTagged} <= {1'h1, len, tg};
		@(posedge clk);
		rxFrameValid <= 1'h0;
		#1 chk("drop", {frameCheckValid, frameDrop}, {1'h1, exp});
	endtask : frm

	task automatic sv(input logic s, input logic d, input logic [11:0] v, input logic m,
		input logic [11:0] e);
		@(posedge clk);
		{sniffValid, rxIgmpValid, vidValid, sniffSrcMatch, sniffDstMatch, vidIn} <= {3'h7, s, d, v};
		@(posedge clk);
		{sniffValid, rxIgmpValid, vidValid} <= 3'h0;
		#1 chk("mirror", sniffMirror, m ? s & d : s | d);
		chk("igmp", igmpToHost, m);
		chk("vid", {vidOutValid, vidOut}, {1'h1, e});
	endtask : sv

	// Grant counts packed one byte per queue, q3 in the top byte
	task automatic pick(input logic [3:0] q, input int n, input logic [31:0] exp);
		logic [31:0] cnt = '0;
		@(posedge clk);
		{queueNotEmpty, txPick} <= {q, 1'h1};
		for (int i = 1; i <= n; i++) begin
			@(posedge clk);
			txPick <= i < n;
			#1 if (grantValid === 1'h1) cnt[8 * grantQueue +: 8] += 8'h01;
		end
		chk("grants", cnt, exp);
	endtask : pick

	initial begin
		{psel, penable, pwrite, rxFrameValid, rxFrameTagged, rxIgmpValid, vidValid} = '0;
		{sniffValid, sniffSrcMatch, sniffDstMatch, txPick, portStrictPrio} = '0;
		{paddr, pwdata, rxFrameLen, queueNotEmpty, vidIn} = '0;
		portVid = 12'h5A3;
		rst_b = 1'h0;
		repeat (8) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		rd(8'h10, 32'hF0, 1'h0);
		rd(8'h14, 32'h00, 1'h0);
		rd(8'h18, 32'h20, 1'h0);
		chk("flow", hostFlowCtrl, 1'h1);
		apb(1'h1, 8'h10, 32'hFE);
		rd(8'h10, 32'hFE, 1'h0);
		apb(1'h1, 8'h14, 32'hFF);
		rd(8'h14, 32'hC9, 1'h0);
		apb(1'h1, 8'h18, 32'hFF);
		rd(8'h18, 32'h7F, 1'h0);
		chk("lvl", {vlanEnable, schedWfq, hostHalfDuplex, hostFlowCtrl, tenMegabitSelect},
			5'h1F);
		apb(1'h1, 8'h18, 32'h0);
		rd(8'h40, 32'h0, 1'h1);
		chk("lvl", {hostHalfDuplex, hostFlowCtrl, tenMegabitSelect}, 3'h0);
		$display("test registers done");
		for (int m = 0; m < 3; m++) begin
			apb(1'h1, 8'h10, {24'h0, 8'hF0 | 8'(2 * m)});
			for (int i = 0; i < 16; i++) begin
				lim = m == 2 ? `SGC_LEN_HUGE : m == 0 ? `SGC_LEN_DEFAULT :
					i[0] ? `SGC_LEN_TAGGED : `SGC_LEN_UNTAGGED;
				frm(lens[i / 2], i[0], lens[i / 2] > lim);
			end
		end
		$display("test frames done");
		for (int m = 0; m < 2; m++) begin
			apb(1'h1, 8'h14, m ? 32'h41 : 32'h00);
			apb(1'h1, 8'h18, m ? 32'h28 : 32'h20);
			for (int i = 0; i < 8; i++)
				sv(i[0], i[1], i[2] ? 12'h000 : 12'h007, m[0],
					i[2] ? (m ? portVid : 12'h000) : 12'h007);
		end
		$display("test strobes done");
		apb(1'h1, 8'h14, 32'h08);
		pick(4'hF, 15, 32'h08040201);
		pick(4'hB, 12, 32'h09000201);
		apb(1'h1, 8'h14, 32'h00);
		portStrictPrio <= 1'h1;
		pick(4'h6, 4, 32'h00040000);
		pick(4'h0, 4, 32'h0);
		portStrictPrio <= 1'h0;
		pick(4'h5, 4, 32'h00020002);
		$display("test scheduler done");
		close_out();
	end
endmodule : sgc_global_ctrl_tb

`default_nettype wire

// file: src/sgc_global_ctrl.sv
// Operation
// - Check off: accept frames up to 1536
// - Check on: drop tagged >1522, untagged >1518
// - Huge bit: accept to 1916, overrides check
// - Bit 7 enables 802.1Q VLAN
// - Snoop bit forwards IGMP to host port
// - WFQ off: per-port priority method schedules
// - Empty queue none; highest non-empty +1 while some queue is empty
// - AND sniff: source and destination match
// - OR sniff: either port matches
// - Bit 6: host MII half duplex
// - Bit 5: host flow control, reset 1
// - Bit 4: host MII 10 Mbps
// - Bit 3: null VID becomes port VID
//
// Design decision made here: the APB slave port.
`include "sgc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sgc_global_ctrl
	import sgc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Received frame length check
	input  wire logic              rxFrameValid,
	input  wire logic [10:0]       rxFrameLen,
	input  wire logic              rxFrameTagged,
	output logic                   frameCheckValid,
	output logic                   frameDrop,
	// IGMP snooping
	input  wire logic              rxIgmpValid,
	output logic                   igmpToHost,
	// Port mirroring
	input  wire logic              sniffValid,
	input  wire logic              sniffSrcMatch,
	input  wire logic              sniffDstMatch,
	output logic                   sniffMirror,
	// Egress scheduling
	input  wire logic [3:0]        queueNotEmpty,
	input  wire logic              txPick,
	input  wire logic              portStrictPrio,
	output logic                   grantValid,
	output logic      [1:0]        grantQueue,
	output logic                   schedWfq,
	// Null VID replacement
	input  wire logic              vidValid,
	input  wire logic [11:0]       vidIn,
	input  wire logic [11:0]       portVid,
	output logic                   vidOutValid,
	output logic      [11:0]       vidOut,
	// Configuration levels
	output logic                   vlanEnable,
	output logic                   hostHalfDuplex,
	output logic                   hostFlowCtrl,
	output logic                   tenMegabitSelect
);

	sgc_reg_t frameSize_q;
	sgc_reg_t vqsCtrl_q;
	sgc_reg_t hostPort_q;

	logic [ADDR_W-3:0] regIdx;
	logic              addrAligned;
	logic              hitFrame;
	logic              hitVqs;
	logic              hitHost;
	logic              mapped;
	logic              wrStrobe;
	logic [7:0]        wrByte;

	assign regIdx      = paddr[ADDR_W-1:2];
	assign addrAligned = (paddr[1:0] == 2'h0);
	assign wrByte      = pwdata[7:0];

	always_comb begin
		hitFrame = 1'b0;
		hitVqs   = 1'b0;
		hitHost  = 1'b0;
		if (!addrAligned) begin
			hitFrame = 1'b0;
		end else if (regIdx == (ADDR_W-2)'(`SGC_IDX_FRAME_SIZE)) begin
			hitFrame = 1'b1;
		end else if (regIdx == (ADDR_W-2)'(`SGC_IDX_VQS_CTRL)) begin
			hitVqs = 1'b1;
		end else if (regIdx == (ADDR_W-2)'(`SGC_IDX_HOST_PORT)) begin
			hitHost = 1'b1;
		end
	end

	assign mapped   = hitFrame | hitVqs | hitHost;
	// Slave answers with zero wait states once out of reset
	assign wrStrobe = psel & penable & pwrite & pready & mapped;

	// Ready is held low only during reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
		end
	end

	// Read data and error prepared in setup so they stand through access
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= ~mapped;
			if (pwrite || !mapped) begin
				prdata <= 32'h0000_0000;
			end else if (hitFrame) begin
				prdata <= {24'h00_0000, frameSize_q};
			end else if (hitVqs) begin
				prdata <= {24'h00_0000, vqsCtrl_q};
			end else begin
				prdata <= {24'h00_0000, hostPort_q};
			end
		end
	end

	// Reserved read-only bits are masked out of every write
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			frameSize_q <= `SGC_RST_FRAME_SIZE;
			vqsCtrl_q   <= `SGC_RST_VQS_CTRL;
			hostPort_q  <= `SGC_RST_HOST_PORT;
		end else if (wrStrobe) begin
			if (hitFrame) begin
				frameSize_q <= wrByte & `SGC_WMASK_FRAME_SIZE;
			end
			if (hitVqs) begin
				vqsCtrl_q <= wrByte & `SGC_WMASK_VQS_CTRL;
			end
			if (hitHost) begin
				hostPort_q <= wrByte & `SGC_WMASK_HOST_PORT;
			end
		end
	end

	// Config bits as registered levels; one cycle behind the register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			vlanEnable       <= 1'b0;
			hostHalfDuplex   <= 1'b0;
			hostFlowCtrl     <= 1'b1;
			tenMegabitSelect <= 1'b0;
			schedWfq         <= 1'b0;
		end else begin
			// Table contents are software's duty before this is set
			vlanEnable       <= vqsCtrl_q[`SGC_BIT_VLAN_EN];
			hostHalfDuplex   <= hostPort_q[`SGC_BIT_HALF_DUPLEX];
			hostFlowCtrl     <= hostPort_q[`SGC_BIT_FLOW_CTRL];
			tenMegabitSelect <= hostPort_q[`SGC_BIT_TEN_MEG];
			schedWfq         <= vqsCtrl_q[`SGC_BIT_WFQ_EN];
		end
	end

	// Frame size limit; huge support wins over the legal check
	logic [10:0] lenLimit;

	always_comb begin
		if (frameSize_q[`SGC_BIT_HUGE]) begin
			lenLimit = `SGC_LEN_HUGE;
		end else if (!frameSize_q[`SGC_BIT_LEGAL_CHK]) begin
			lenLimit = `SGC_LEN_DEFAULT;
		end else if (rxFrameTagged) begin
			lenLimit = `SGC_LEN_TAGGED;
		end else begin
			lenLimit = `SGC_LEN_UNTAGGED;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			frameCheckValid <= 1'b0;
			frameDrop       <= 1'b0;
		end else begin
			frameCheckValid <= rxFrameValid;
			frameDrop       <= rxFrameValid & (rxFrameLen > lenLimit);
		end
	end

	// IGMP snoop and mirroring decisions
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			igmpToHost  <= 1'b0;
			sniffMirror <= 1'b0;
		end else begin
			igmpToHost <= rxIgmpValid & vqsCtrl_q[`SGC_BIT_IGMP_SNOOP];
			if (!sniffValid) begin
				sniffMirror <= 1'b0;
			end else if (vqsCtrl_q[`SGC_BIT_SNIFF_AND]) begin
				sniffMirror <= sniffSrcMatch & sniffDstMatch;
			end else begin
				sniffMirror <= sniffSrcMatch | sniffDstMatch;
			end
		end
	end

	// Egress scheduler
	sgc_sched_t schedMode;
	logic [3:0] weight [4];
	logic [3:0] credit_q [4];
	logic [3:0] credit_d [4];
	logic [3:0] eligible;
	logic [3:0] topNonEmpty;
	logic [1:0] pick;
	logic       pickOk;
	logic       reload;
	logic [1:0] rrLast_q;

	always_comb begin
		if (vqsCtrl_q[`SGC_BIT_WFQ_EN]) begin
			schedMode = SGC_SCHED_WFQ;
		end else if (portStrictPrio) begin
			schedMode = SGC_SCHED_STRICT;
		end else begin
			schedMode = SGC_SCHED_RR;
		end
	end

	// One-hot of the highest queue holding frames
	always_comb begin
		topNonEmpty = 4'h0;
		if (queueNotEmpty[3]) begin
			topNonEmpty = 4'h8;
		end else if (queueNotEmpty[2]) begin
			topNonEmpty = 4'h4;
		end else if (queueNotEmpty[1]) begin
			topNonEmpty = 4'h2;
		end else if (queueNotEmpty[0]) begin
			topNonEmpty = 4'h1;
		end
	end

	// Credits run out for every busy queue before a reload
	assign reload = ((queueNotEmpty[3] && credit_q[3] != 4'h0) ||
			(queueNotEmpty[2] && credit_q[2] != 4'h0) ||
			(queueNotEmpty[1] && credit_q[1] != 4'h0) ||
			(queueNotEmpty[0] && credit_q[0] != 4'h0)) ? 1'b0 : 1'b1;

	genvar gq;
	generate
		for (gq = 0; gq < 4; gq++) begin : gQueue
			logic [3:0] baseW;
			assign baseW = (gq == 3) ? `SGC_WEIGHT_Q3 :
					(gq == 2) ? `SGC_WEIGHT_Q2 :
					(gq == 1) ? `SGC_WEIGHT_Q1 : `SGC_WEIGHT_Q0;
			// Empty gets nothing; top busy queue one extra only while some queue idles
			assign weight[gq] = !queueNotEmpty[gq] ? 4'h0 :
					baseW + {3'h0, topNonEmpty[gq] & ~(&queueNotEmpty)};
			assign eligible[gq] = queueNotEmpty[gq] &&
					((reload ? weight[gq] : credit_q[gq]) != 4'h0);
		end
	endgenerate

	always_comb begin
		pick   = 2'h0;
		pickOk = 1'b0;
		case (schedMode)
			SGC_SCHED_WFQ: begin
				// Higher queues spend their credits first in each round
				if (eligible[3]) begin
					pick = 2'h3;
				end else if (eligible[2]) begin
					pick = 2'h2;
				end else if (eligible[1]) begin
					pick = 2'h1;
				end else begin
					pick = 2'h0;
				end
				pickOk = |eligible;
			end
			SGC_SCHED_RR: begin
				for (int k = 1; k <= 4; k++) begin
					if (!pickOk && queueNotEmpty[2'(rrLast_q + 2'(k))]) begin
						pick   = 2'(rrLast_q + 2'(k));
						pickOk = 1'b1;
					end
				end
			end
			default: begin
				pick   = topNonEmpty[3] ? 2'h3 : topNonEmpty[2] ? 2'h2 :
						topNonEmpty[1] ? 2'h1 : 2'h0;
				pickOk = |queueNotEmpty;
			end
		endcase
	end

	always_comb begin
		for (int k = 0; k < 4; k++) begin
			credit_d[k] = credit_q[k];
		end
		if (txPick && pickOk && schedMode == SGC_SCHED_WFQ) begin
			for (int k = 0; k < 4; k++) begin
				credit_d[k] = reload ? weight[k] : credit_q[k];
			end
			credit_d[pick] = credit_d[pick] - 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int k = 0; k < 4; k++) begin
				credit_q[k] <= 4'h0;
			end
		end else begin
			for (int k = 0; k < 4; k++) begin
				credit_q[k] <= credit_d[k];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			grantValid <= 1'b0;
			grantQueue <= 2'h0;
			rrLast_q   <= 2'h3;
		end else begin
			grantValid <= txPick & pickOk;
			if (txPick && pickOk) begin
				grantQueue <= pick;
				rrLast_q   <= pick;
			end
		end
	end

	// Null VID replacement
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			vidOutValid <= 1'b0;
			vidOut      <= 12'h000;
		end else begin
			vidOutValid <= vidValid;
			if (vidValid) begin
				if (hostPort_q[`SGC_BIT_NULL_VID] && vidIn == 12'h000) begin
					vidOut <= portVid;
				end else begin
					vidOut <= vidIn;
				end
			end
		end
	end

endmodule : sgc_global_ctrl

`default_nettype wire

// file: src/sgc_pkg.sv
package sgc_pkg;

	typedef enum logic [1:0] {
		SGC_SCHED_STRICT = 2'b00,
		SGC_SCHED_RR     = 2'b01,
		SGC_SCHED_WFQ    = 2'b10
	} sgc_sched_t;

	typedef logic [7:0] sgc_reg_t;

endpackage : sgc_pkg

// file: src/sgc_regs.svh
`ifndef SGC_REGS_SVH
`define SGC_REGS_SVH

// Register indices; byte address is four times the index
`define SGC_IDX_FRAME_SIZE   6'h04
`define SGC_IDX_VQS_CTRL     6'h05
`define SGC_IDX_HOST_PORT    6'h06

// Reset values
`define SGC_RST_FRAME_SIZE   8'hF0
`define SGC_RST_VQS_CTRL     8'h00
`define SGC_RST_HOST_PORT    8'h20

// Writable bit masks
`define SGC_WMASK_FRAME_SIZE 8'hFF
`define SGC_WMASK_VQS_CTRL   8'hC9
`define SGC_WMASK_HOST_PORT  8'h7F

// Field positions
`define SGC_BIT_HUGE         2
`define SGC_BIT_LEGAL_CHK    1
`define SGC_BIT_VLAN_EN      7
`define SGC_BIT_IGMP_SNOOP   6
`define SGC_BIT_WFQ_EN       3
`define SGC_BIT_SNIFF_AND    0
`define SGC_BIT_HALF_DUPLEX  6
`define SGC_BIT_FLOW_CTRL    5
`define SGC_BIT_TEN_MEG      4
`define SGC_BIT_NULL_VID     3

// Frame length limits in bytes
`define SGC_LEN_HUGE         11'd1916
`define SGC_LEN_DEFAULT      11'd1536
`define SGC_LEN_TAGGED       11'd1522
`define SGC_LEN_UNTAGGED     11'd1518

// Queue weights, q3 down to q0
`define SGC_WEIGHT_Q3        4'h8
`define SGC_WEIGHT_Q2        4'h4
`define SGC_WEIGHT_Q1        4'h2
`define SGC_WEIGHT_Q0        4'h1

`endif
